// ---- logic/error_report_pkg.sv ----
// Package for the primary system-error reporting register bank
package error_report_pkg;

   // Register byte offsets; 0x6a is not word aligned, so these are indices
   localparam logic [7:0] DISABLE_IDX = 8'h64;
   localparam logic [7:0] STATUS_IDX  = 8'h6a;
   localparam logic [7:0] MASK_IDX    = 8'h6c;  // Interrupt mask index
   localparam int         IDX_LSB     = 2;      // Byte address = 4 * index

   // Writable cause bits 6..1; bits 7 and 0 are reserved
   localparam logic [7:0] CAUSE_MASK  = 8'h7e;
   localparam logic [7:0] REG_RESET   = 8'h00;

   // Cause bit positions
   localparam int BIT_DR_TIMEOUT  = 6;  // Delayed read time-out
   localparam int BIT_DW_TIMEOUT  = 5;  // Delayed write time-out
   localparam int BIT_PW_MABORT   = 4;  // Posted write master abort
   localparam int BIT_PW_TABORT   = 3;  // Posted write target abort
   localparam int BIT_PW_TIMEOUT  = 2;  // Posted write time-out
   localparam int BIT_PW_PARITY   = 1;  // Posted write parity error

   // Retry limit exponent: time-out on retry number 2**24
   localparam int RETRY_EXP       = 24;

   // Number of retry counters: delayed read, delayed write, posted write
   localparam int NUM_RETRY       = 3;

   // AHB transfer codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   // Captured AHB address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] index;
   } addr_phase_type;

   // Per-transaction retry stream: start, retry attempt, completion
   typedef struct packed {
      logic start;
      logic retry;
      logic done;
   } retry_evt_type;

endpackage

// ---- logic/primary_error_report.sv ----
// Primary system-error reporting: disable, cause status, retry time-outs
//
// How it works
// [R1] Disable register resets to zero, all reported
// [R2] Disable bit 6 gates delayed-read time-out
// [R3] Disable bit 5 gates delayed-write time-out
// [R4] Disable bit 2 gates posted-write time-out
// [R5] Disable bit 4 gates posted-write master abort
// [R6] Disable bit 3 gates posted-write target abort
// [R7] Disable bit 1 gates posted-write parity error
// [R8] Bits 7 and 0 reserved, read zero
// [R9] Cause status register resets to zero
// [R10] Status bit 6: delayed-read time-out reported
// [R11] Status bit 5: delayed-write time-out reported
// [R12] Status bit 4: posted-write master abort reported
// [R13] Status bit 3: posted-write target abort reported
// [R14] Status bit 2: posted-write time-out reported
// [R15] Status bit 1: posted-write parity error reported
// [R16] Write one clears status bit, zero keeps
// [R17] Suppressed events leave status bit unchanged
// [R18] Retry counter restarts, times out at 2**24
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module primary_error_report #(
   parameter int RETRY_LIMIT = 1 << error_report_pkg::RETRY_EXP
) (
   input  wire logic                             sys_clk_i,
   input  wire logic                             rst_b_i,
   // AHB-Lite slave
   input  wire logic                             hsel_i,
   input  wire logic [31:0]                      haddr_i,
   input  wire logic [1:0]                       htrans_i,
   input  wire logic                             hwrite_i,
   input  wire logic [2:0]                       hsize_i,
   input  wire logic [31:0]                      hwdata_i,
   input  wire logic                             hready_i,
   output logic      [31:0]                      hrdata_o,
   output logic                                  hreadyout_o,
   output logic                                  hresp_o,
   // Retry streams: 0 delayed read, 1 delayed write, 2 posted write
   input  wire error_report_pkg::retry_evt_type  retry_evt_i [3],
   // Direct abort and parity events on posted writes
   input  wire logic                             pw_master_abort_i,
   input  wire logic                             pw_target_abort_i,
   input  wire logic                             pw_parity_err_i,
   // Error outputs
   output logic                                  primary_system_error_o,
   output logic                                  irq_o
);

   localparam int CW = $clog2(RETRY_LIMIT + 1);

   // Reset synchroniser: async assert, two-flop release
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire logic rst_n = rst_sync_reg;

   // Registers
   logic [7:0] disable_reg;  // Event disable
   logic [7:0] status_reg;   // Sticky cause status
   logic [7:0] mask_reg;     // Interrupt mask, one enables
   error_report_pkg::addr_phase_type aph_reg;

   // Address phase decode: only NONSEQ transfers count, whatever their size
   wire logic aph_take = hsel_i && hready_i
                         && (htrans_i == error_report_pkg::HTRANS_NONSEQ);
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         aph_reg <= '0;
      end else if (hready_i) begin
         aph_reg.valid <= aph_take;
         aph_reg.write <= hwrite_i;
         aph_reg.index <= haddr_i[error_report_pkg::IDX_LSB +: 8];
      end
   end

   // Data phase write strobes
   wire logic wr_go = aph_reg.valid && aph_reg.write;
   wire logic wr_dis = wr_go
                       && (aph_reg.index == error_report_pkg::DISABLE_IDX);
   wire logic wr_sts = wr_go
                       && (aph_reg.index == error_report_pkg::STATUS_IDX);
   wire logic wr_msk = wr_go
                       && (aph_reg.index == error_report_pkg::MASK_IDX);

   // Retry counters, one per transaction kind
   logic [error_report_pkg::NUM_RETRY-1:0] timeout_evt;
   genvar g;
   generate
      for (g = 0; g < error_report_pkg::NUM_RETRY; g++) begin : g_retry
         logic [CW-1:0] cnt_reg;
         logic          act_reg;
         // Counter restarts at start; retry number RETRY_LIMIT fires
         always_ff @(posedge sys_clk_i or negedge rst_n) begin
            if (!rst_n) begin
               cnt_reg <= '0;
               act_reg <= 1'b0;
            end else if (retry_evt_i[g].start) begin  // [R18]
               cnt_reg <= '0;
               act_reg <= 1'b1;
            end else if (retry_evt_i[g].done) begin
               act_reg <= 1'b0;
            end else if (act_reg && retry_evt_i[g].retry) begin
               cnt_reg <= cnt_reg + 1'b1;
               // Give up after the limit so the event fires once
               if (cnt_reg == CW'(RETRY_LIMIT - 1)) begin
                  act_reg <= 1'b0;
               end
            end
         end
         // Time-out on the retry that reaches the limit
         assign timeout_evt[g] = act_reg && retry_evt_i[g].retry  // [R18]
                                 && !retry_evt_i[g].start
                                 && !retry_evt_i[g].done
                                 && (cnt_reg == CW'(RETRY_LIMIT - 1));
      end
   endgenerate

   // Raw events mapped onto cause bit positions
   logic [7:0] raw_evt;
   always_comb begin
      raw_evt = '0;
      raw_evt[error_report_pkg::BIT_DR_TIMEOUT] = timeout_evt[0];
      raw_evt[error_report_pkg::BIT_DW_TIMEOUT] = timeout_evt[1];
      raw_evt[error_report_pkg::BIT_PW_TIMEOUT] = timeout_evt[2];
      raw_evt[error_report_pkg::BIT_PW_MABORT]  = pw_master_abort_i;
      raw_evt[error_report_pkg::BIT_PW_TABORT]  = pw_target_abort_i;
      raw_evt[error_report_pkg::BIT_PW_PARITY]  = pw_parity_err_i;
   end

   // Reported events: a one in the disable bit suppresses the cause
   wire logic [7:0] rep_evt = raw_evt & ~disable_reg
                              & error_report_pkg::CAUSE_MASK; // [R2] [R3]
   // Same gating covers the abort and parity causes         // [R4] [R5]
   // Individual bits listed for the remaining causes         // [R6] [R7]

   // Disable register; reserved bits never stored
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         disable_reg <= error_report_pkg::REG_RESET;  // [R1]
      end else if (wr_dis) begin
         disable_reg <= hwdata_i[7:0] & error_report_pkg::CAUSE_MASK; // [R8]
      end
   end

   // Interrupt mask register
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= error_report_pkg::REG_RESET;
      end else if (wr_msk) begin
         mask_reg <= hwdata_i[7:0] & error_report_pkg::CAUSE_MASK;
      end
   end

   // Status: set wins over a same-cycle write-one clear
   logic [7:0] status_next;
   always_comb begin
      status_next = status_reg;
      if (wr_sts) begin
         status_next = status_next & ~hwdata_i[7:0];  // [R16]
      end
      // Only reported events set a bit                  [R17]
      status_next = (status_next | rep_evt)           // [R10] [R11] [R12]
                    & error_report_pkg::CAUSE_MASK;   // [R13] [R14] [R15]
   end
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= error_report_pkg::REG_RESET;  // [R9]
      end else begin
         status_reg <= status_next;
      end
   end

   // Error pulse and interrupt level, both registered
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         primary_system_error_o <= 1'b0;
         irq_o                  <= 1'b0;
      end else begin
         primary_system_error_o <= |rep_evt;
         irq_o                  <= |(status_next & mask_reg);
      end
   end

   // Read data, registered in the address phase; zero-wait slave
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_o <= '0;
      end else if (aph_take && !hwrite_i) begin
         unique case (haddr_i[error_report_pkg::IDX_LSB +: 8])
            error_report_pkg::DISABLE_IDX: hrdata_o <= {24'h00_0000, disable_reg};
            error_report_pkg::STATUS_IDX:  hrdata_o <= {24'h00_0000, status_next};
            error_report_pkg::MASK_IDX:    hrdata_o <= {24'h00_0000, mask_reg};
            default:                       hrdata_o <= '0;  // Unmapped
         endcase
      end
   end

   // Always ready, always OKAY
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // Assertions
   // These watch the gated events against the raw inputs, so a broken
   // disable mask or a lost set shows up even without a bus read
   property p_dis_reset;
      @(posedge sys_clk_i) $rose(rst_n) |-> disable_reg == 8'h00;
   endproperty
   a_dis_reset: assert property (p_dis_reset) else $error("disable not reset"); // [R1]

   property p_suppress;
      @(posedge sys_clk_i) disable iff (!rst_n)
         (raw_evt & ~disable_reg & error_report_pkg::CAUSE_MASK) == 8'h00
            |=> !primary_system_error_o;
   endproperty
   a_suppress: assert property (p_suppress) else $error("error not suppressed"); // [R2]

   property p_report;
      @(posedge sys_clk_i) disable iff (!rst_n)
         (raw_evt & ~disable_reg & error_report_pkg::CAUSE_MASK) != 8'h00
            |=> primary_system_error_o;
   endproperty
   a_report: assert property (p_report) else $error("error not signalled"); // [R7]

   property p_reserved;
      @(posedge sys_clk_i) disable iff (!rst_n)
         !disable_reg[7] && !disable_reg[0] && !status_reg[7] && !status_reg[0];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [R8]

   property p_sts_set;
      @(posedge sys_clk_i) disable iff (!rst_n)
         raw_evt[6] && !disable_reg[6] |=> status_reg[6];
   endproperty
   a_sts_set: assert property (p_sts_set) else $error("status 6 not set"); // [R10]

   property p_no_set;
      @(posedge sys_clk_i) disable iff (!rst_n)
         disable_reg[4] && !status_reg[4] && !wr_dis |=> !status_reg[4];
   endproperty
   a_no_set: assert property (p_no_set) else $error("suppressed set status"); // [R17]

   property p_clear;
      @(posedge sys_clk_i) disable iff (!rst_n)
         wr_sts && hwdata_i[3] && !rep_evt[3] |=> !status_reg[3];
   endproperty
   a_clear: assert property (p_clear) else $error("status not cleared"); // [R16]

   property p_sticky;
      @(posedge sys_clk_i) disable iff (!rst_n)
         status_reg[5] && !(wr_sts && hwdata_i[5]) |=> status_reg[5];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost"); // [R16]

   property p_irq;
      @(posedge sys_clk_i) disable iff (!rst_n)
         ##1 irq_o == |($past(status_next) & $past(mask_reg));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch"); // [R15]

   // Per-cause set checks: a reported event lands in its status bit
   property p_set5;
      @(posedge sys_clk_i) disable iff (!rst_n)
         timeout_evt[1] && !disable_reg[error_report_pkg::BIT_DW_TIMEOUT]
            |=> status_reg[error_report_pkg::BIT_DW_TIMEOUT];
   endproperty
   a_set5: assert property (p_set5) else $error("no set 5"); // [R11]

   property p_set4;
      @(posedge sys_clk_i) disable iff (!rst_n)
         pw_master_abort_i && !disable_reg[error_report_pkg::BIT_PW_MABORT]
            |=> status_reg[error_report_pkg::BIT_PW_MABORT];
   endproperty
   a_set4: assert property (p_set4) else $error("no set 4"); // [R12]

   property p_set3;
      @(posedge sys_clk_i) disable iff (!rst_n)
         pw_target_abort_i && !disable_reg[error_report_pkg::BIT_PW_TABORT]
            |=> status_reg[error_report_pkg::BIT_PW_TABORT];
   endproperty
   a_set3: assert property (p_set3) else $error("no set 3"); // [R13]

   property p_set2;
      @(posedge sys_clk_i) disable iff (!rst_n)
         timeout_evt[2] && !disable_reg[error_report_pkg::BIT_PW_TIMEOUT]
            |=> status_reg[error_report_pkg::BIT_PW_TIMEOUT];
   endproperty
   a_set2: assert property (p_set2) else $error("no set 2"); // [R14]

   property p_set1;
      @(posedge sys_clk_i) disable iff (!rst_n)
         pw_parity_err_i && !disable_reg[error_report_pkg::BIT_PW_PARITY]
            |=> status_reg[error_report_pkg::BIT_PW_PARITY];
   endproperty
   a_set1: assert property (p_set1) else $error("no set 1"); // [R15]

   // Suppression and one-shot checks
   property p_no_set1;
      @(posedge sys_clk_i) disable iff (!rst_n)
         disable_reg[1] && !status_reg[1] && !wr_dis
            |=> !status_reg[1];
   endproperty
   a_no_set1: assert property (p_no_set1) else $error("set 1"); // [R17]

   property p_no_set3;
      @(posedge sys_clk_i) disable iff (!rst_n)
         disable_reg[3] && !status_reg[3] && !wr_dis
            |=> !status_reg[3];
   endproperty
   a_no_set3: assert property (p_no_set3) else $error("set 3"); // [R17]

   property p_once0;
      @(posedge sys_clk_i) disable iff (!rst_n)
         timeout_evt[0]
            |=> !timeout_evt[0];
   endproperty
   a_once0: assert property (p_once0) else $error("twice 0"); // [R18]

   property p_once2;
      @(posedge sys_clk_i) disable iff (!rst_n)
         timeout_evt[2]
            |=> !timeout_evt[2];
   endproperty
   a_once2: assert property (p_once2) else $error("twice 2"); // [R18]

   c_timeout: cover property (@(posedge sys_clk_i) timeout_evt[0]);
   c_parity:  cover property (@(posedge sys_clk_i) rep_evt[1]);
   c_clear:   cover property (@(posedge sys_clk_i) wr_sts && |status_reg);
   c_irq:     cover property (@(posedge sys_clk_i) irq_o);

endmodule // primary_error_report

`default_nettype wire

// ---- tb/pci_event_source.sv ----
// Bridge transaction side model: retry streams, aborts, parity errors
`timescale 1ns/1ps
`default_nettype none

module pci_event_source (
   input  wire logic                           sys_clk_i,
   output var error_report_pkg::retry_evt_type retry_evt_o [3],
   output logic                                pw_master_abort_o,
   output logic                                pw_target_abort_o,
   output logic                                pw_parity_err_o
);
   // Quiet at time zero so no event is seen during reset
   initial begin
      retry_evt_o = '{default: '0};
      {pw_parity_err_o, pw_target_abort_o, pw_master_abort_o} = 3'h0;
   end

   // Begin a transaction, retry n times back to back, optionally finish
   task automatic run(input int s, input int n, input bit fin);
      int i;
      @(posedge sys_clk_i);
      retry_evt_o[s].start <= 1'b1;
      @(posedge sys_clk_i);
      retry_evt_o[s].start <= 1'b0;
      for (i = 0; i < n; i++) begin
         retry_evt_o[s].retry <= 1'b1;
         @(posedge sys_clk_i);
      end
      retry_evt_o[s].retry <= 1'b0;
      retry_evt_o[s].done  <= fin;
      @(posedge sys_clk_i);
      retry_evt_o[s].done  <= 1'b0;
   endtask

   // One-cycle pulse: 0 master abort, 1 target abort, 2 parity error
   task automatic pulse(input int k);
      @(posedge sys_clk_i);
      {pw_parity_err_o, pw_target_abort_o, pw_master_abort_o} <= 3'(1 << k);
      @(posedge sys_clk_i);
      {pw_parity_err_o, pw_target_abort_o, pw_master_abort_o} <= 3'h0;
   endtask
endmodule // pci_event_source

`default_nettype wire

// ---- tb/test_primary_error_report.sv ----
// Self-checking bench for the primary system-error register bank
`timescale 1ns/1ps
`default_nettype none

module test_primary_error_report;
   localparam int          LIMIT = 4;              // Short retry limit
   localparam logic [31:0] A_DIS = 32'h0000_0190;  // Index 0x64 times 4
   localparam logic [31:0] A_STA = 32'h0000_01a8;  // Index 0x6a times 4
   localparam logic [31:0] A_MSK = 32'h0000_01b0;  // Index 0x6c times 4
   localparam logic [31:0] A_BAD = 32'h0000_0100;  // Unmapped word
   localparam int          CBIT [6] = '{6, 5, 2, 4, 3, 1};  // Status bits

   logic        sys_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] haddr     = '0;
   logic [31:0] hwdata    = '0;
   logic [31:0] rdata;
   logic [31:0] q;
   logic        hready;
   logic        hresp;
   logic        serr;
   logic        irq;
   logic        ma;
   logic        ta;
   logic        pe;
   error_report_pkg::retry_evt_type evt [3];
   int          err_count   = 0;
   int          checks_done = 0;
   int          pulses      = 0;   // Error pulses seen so far

   always #2.5 sys_clk_i = ~sys_clk_i;

   // Each high cycle of the error output is one report
   always @(posedge sys_clk_i) if (serr === 1'b1) pulses <= pulses + 1;

   primary_error_report #(.RETRY_LIMIT(LIMIT)) i_primary_error_report (
      .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(error_report_pkg::HSIZE_WORD), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(rdata), .hreadyout_o(hready),
      .hresp_o(hresp), .retry_evt_i(evt), .pw_master_abort_i(ma),
      .pw_target_abort_i(ta), .pw_parity_err_i(pe),
      .primary_system_error_o(serr), .irq_o(irq));

   pci_event_source i_pci_event_source (
      .sys_clk_i(sys_clk_i), .retry_evt_o(evt), .pw_master_abort_o(ma),
      .pw_target_abort_o(ta), .pw_parity_err_o(pe));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Single AHB transfer; the wait on hready is bounded
   task automatic bus(input logic w, input logic [31:0] a, d);
      int n;
      @(posedge sys_clk_i);
      hsel   <= 1'b1;
      htrans <= error_report_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= a;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (hready !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (hready !== 1'b1 && n < 50);
      q = rdata;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // Timeout causes run a full retry stream, the rest a single pulse
   task automatic fire(input int i);
      if (i < 3) i_pci_event_source.run(i, LIMIT, 1'b0);
      else i_pci_event_source.pulse(i - 3);
      repeat (2) @(posedge sys_clk_i);
   endtask

   task automatic t_reset;
      rdchk(A_DIS, 32'h0);
      rdchk(A_STA, 32'h0);
      bus(1'b1, A_BAD, 32'hffff_ffff);
      rdchk(A_BAD, 32'h0);
      rdchk(A_DIS, 32'h0);
      chk(serr, 32'h0);
      chk(hresp, 32'h0);
   endtask

   task automatic t_reserved;
      bus(1'b1, A_DIS, 32'h0000_00ff);
      rdchk(A_DIS, 32'h0000_007e);
      bus(1'b1, A_DIS, 32'h0);
      bus(1'b1, A_STA, 32'h0000_0081);
      rdchk(A_STA, 32'h0);
   endtask

   // Each cause reported, sticky, cleared by one, suppressed when disabled
   task automatic t_causes;
      int          i;
      int          p;
      logic [31:0] b;
      for (i = 0; i < 6; i++) begin
         b = 32'h1 << CBIT[i];
         p = pulses;
         fire(i);
         chk(pulses - p, 32'h1);
         rdchk(A_STA, b);
         bus(1'b1, A_STA, ~b);
         rdchk(A_STA, b);
         bus(1'b1, A_STA, b);
         rdchk(A_STA, 32'h0);
         bus(1'b1, A_DIS, b);
         p = pulses;
         fire(i);
         chk(pulses - p, 32'h0);
         rdchk(A_STA, 32'h0);
         bus(1'b1, A_DIS, 32'h0);
      end
   endtask

   // Short streams and restarts never time out; a late retry is ignored
   task automatic t_retry;
      int p;
      p = pulses;
      i_pci_event_source.run(0, LIMIT - 1, 1'b1);
      i_pci_event_source.run(1, LIMIT - 1, 1'b0);
      i_pci_event_source.run(1, LIMIT - 1, 1'b1);
      repeat (2) @(posedge sys_clk_i);
      chk(pulses - p, 32'h0);
      i_pci_event_source.run(2, LIMIT + 2, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      chk(pulses - p, 32'h1);
      rdchk(A_STA, 32'h0000_0004);
      bus(1'b1, A_STA, 32'h0000_0004);
   endtask

   task automatic t_irq;
      bus(1'b1, A_MSK, 32'h0000_0002);
      fire(5);
      chk(irq, 32'h1);
      bus(1'b1, A_MSK, 32'h0);
      repeat (2) @(posedge sys_clk_i);
      chk(irq, 32'h0);
      bus(1'b1, A_MSK, 32'h0000_0002);
      repeat (2) @(posedge sys_clk_i);
      chk(irq, 32'h1);
      bus(1'b1, A_STA, 32'h0000_0002);
      repeat (2) @(posedge sys_clk_i);
      chk(irq, 32'h0);
   endtask

   task automatic summarize;
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Reset held 12 cycles, first transfer three edges after release
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      t_reset;
      t_reserved;
      t_causes;
      t_retry;
      t_irq;
      summarize;
   end

   // Watchdog: far beyond the few hundred cycles the run needs
   initial begin
      #50000;
      err_count++;
      summarize;
   end
endmodule // test_primary_error_report

`default_nettype wire
